// [rsr_regs.sv]
// Register bank controlling supply and retention of the two sections of RAM blocks 3 to 5
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns

module rsr_regs #(
	parameter int unsigned NUM_BLOCKS = rsr_pkg::NUM_BLOCKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [rsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic sys_off_req,
	output logic [NUM_BLOCKS-1:0] sec0_supply_on,
	output logic [NUM_BLOCKS-1:0] sec1_supply_on,
	output logic [NUM_BLOCKS-1:0] sec0_retain,
	output logic [NUM_BLOCKS-1:0] sec1_retain
);

	// ****************************************
	// Address decode
	// ****************************************

	typedef enum logic [2:0] {
		RSR_ACC_NONE = 3'b000,
		RSR_ACC_RW = 3'b001,
		RSR_ACC_SET = 3'b010,
		RSR_ACC_CLR = 3'b100
	} rsr_acc_t;

	// Block index and access kind for an address; unmapped gives RSR_ACC_NONE
	function automatic rsr_acc_t rsr_kind(input logic [rsr_pkg::ADDR_W-1:0] a);
		if (a == rsr_pkg::RAM3_SECTION_CTRL_OFS || a == rsr_pkg::RAM4_SECTION_CTRL_OFS ||
			a == rsr_pkg::RAM5_SECTION_CTRL_OFS) begin
			return RSR_ACC_RW;
		end else if (a == rsr_pkg::RAM3_SECTION_CTRL_SET_OFS ||
			a == rsr_pkg::RAM4_SECTION_CTRL_SET_OFS) begin
			return RSR_ACC_SET;
		end else if (a == rsr_pkg::RAM3_SECTION_CTRL_CLEAR_OFS ||
			a == rsr_pkg::RAM4_SECTION_CTRL_CLEAR_OFS) begin
			return RSR_ACC_CLR;
		end else begin
			return RSR_ACC_NONE;
		end
	endfunction

	function automatic logic [1:0] rsr_block(input logic [rsr_pkg::ADDR_W-1:0] a);
		if (a[7:4] == rsr_pkg::RAM3_SECTION_CTRL_OFS[7:4]) begin
			return 2'h0;
		end else if (a[7:4] == rsr_pkg::RAM4_SECTION_CTRL_OFS[7:4]) begin
			return 2'h1;
		end else begin
			return 2'h2;
		end
	endfunction

	rsr_acc_t acc_kind;
	logic [1:0] acc_blk;

	always_comb begin
		acc_kind = rsr_kind(reg_addr);
		acc_blk = rsr_block(reg_addr);
	end

	// ****************************************
	// Control registers
	// ****************************************

	// One bit per block for each field; the full word is only rebuilt for reads
	logic [NUM_BLOCKS-1:0] on0_q;
	logic [NUM_BLOCKS-1:0] on1_q;
	logic [NUM_BLOCKS-1:0] keep0_q;
	logic [NUM_BLOCKS-1:0] keep1_q;

	// Reset image of each field, one copy per block
	localparam logic [NUM_BLOCKS-1:0] ON0_RST =
		{NUM_BLOCKS{rsr_pkg::CTRL_RESET[rsr_pkg::SEC0_ON_BIT]}};
	localparam logic [NUM_BLOCKS-1:0] ON1_RST =
		{NUM_BLOCKS{rsr_pkg::CTRL_RESET[rsr_pkg::SEC1_ON_BIT]}};
	localparam logic [NUM_BLOCKS-1:0] KEEP0_RST =
		{NUM_BLOCKS{rsr_pkg::CTRL_RESET[rsr_pkg::SEC0_KEEP_BIT]}};
	localparam logic [NUM_BLOCKS-1:0] KEEP1_RST =
		{NUM_BLOCKS{rsr_pkg::CTRL_RESET[rsr_pkg::SEC1_KEEP_BIT]}};

	// ****************************************
	// Write strobes
	// ****************************************

	logic [NUM_BLOCKS-1:0] blk_hit;
	logic [NUM_BLOCKS-1:0] wr_rw;
	logic [NUM_BLOCKS-1:0] wr_set;
	logic [NUM_BLOCKS-1:0] wr_clr;

	// One-hot block select shared by writes and reads; unmapped offsets select nothing
	always_comb begin
		blk_hit = '0;
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			blk_hit[i] = (acc_kind != RSR_ACC_NONE) && (acc_blk == 2'(i));
		end
	end

	always_comb begin
		wr_rw = '0;
		wr_set = '0;
		wr_clr = '0;
		if (reg_wr) begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				wr_rw[i] = blk_hit[i] && (acc_kind == RSR_ACC_RW);
				wr_set[i] = blk_hit[i] && (acc_kind == RSR_ACC_SET);
				wr_clr[i] = blk_hit[i] && (acc_kind == RSR_ACC_CLR);
			end
		end
	end

	// ****************************************
	// Field update
	// ****************************************

	// Next value of one field bit; a zero written to an alias leaves the bit alone
	function automatic logic rsr_bit_next(
		input logic cur,
		input logic wbit,
		input logic rw_en,
		input logic set_en,
		input logic clr_en
	);
		logic nxt;
		nxt = cur;
		if (rw_en) begin
			nxt = wbit;
		end else if (set_en && wbit) begin
			nxt = 1'b1;
		end else if (clr_en && wbit) begin
			nxt = 1'b0;
		end
		return nxt;
	endfunction

	// ****************************************
	// Field registers
	// ****************************************

	// Section 0 on bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			on0_q <= ON0_RST;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				if (wr_rw[i] || wr_set[i] || wr_clr[i]) begin
					on0_q[i] <= rsr_bit_next(on0_q[i], reg_wdata[rsr_pkg::SEC0_ON_BIT],
						wr_rw[i], wr_set[i], wr_clr[i]);
				end
			end
		end
	end

	// Section 1 on bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			on1_q <= ON1_RST;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				if (wr_rw[i] || wr_set[i] || wr_clr[i]) begin
					on1_q[i] <= rsr_bit_next(on1_q[i], reg_wdata[rsr_pkg::SEC1_ON_BIT],
						wr_rw[i], wr_set[i], wr_clr[i]);
				end
			end
		end
	end

	// Section 0 retention bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			keep0_q <= KEEP0_RST;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				if (wr_rw[i] || wr_set[i] || wr_clr[i]) begin
					keep0_q[i] <= rsr_bit_next(keep0_q[i], reg_wdata[rsr_pkg::SEC0_KEEP_BIT],
						wr_rw[i], wr_set[i], wr_clr[i]);
				end
			end
		end
	end

	// Section 1 retention bits
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			keep1_q <= KEEP1_RST;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				if (wr_rw[i] || wr_set[i] || wr_clr[i]) begin
					keep1_q[i] <= rsr_bit_next(keep1_q[i], reg_wdata[rsr_pkg::SEC1_KEEP_BIT],
						wr_rw[i], wr_set[i], wr_clr[i]);
				end
			end
		end
	end

	// ****************************************
	// System-off latch
	// ****************************************

	logic sys_off_q;

	// Held until reset: waking from system off goes through reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sys_off_q <= 1'b0;
		end else if (sys_off_req) begin
			sys_off_q <= 1'b1;
		end
	end

	// ****************************************
	// Readback words
	// ****************************************

	// Reserved bits hold the reset image, so a read shows them the same as after reset
	function automatic logic [31:0] rsr_word(
		input logic on0,
		input logic on1,
		input logic keep0,
		input logic keep1
	);
		logic [31:0] w;
		w = rsr_pkg::CTRL_RESET & ~rsr_pkg::CTRL_MASK;
		w[rsr_pkg::SEC0_ON_BIT] = on0;
		w[rsr_pkg::SEC1_ON_BIT] = on1;
		w[rsr_pkg::SEC0_KEEP_BIT] = keep0;
		w[rsr_pkg::SEC1_KEEP_BIT] = keep1;
		return w;
	endfunction

	logic [31:0] ctrl_word [NUM_BLOCKS];
	logic [31:0] rd_word;

	// Unmapped reads give zero so a stray read never looks like a live register
	always_comb begin
		rd_word = 32'h0000_0000;
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			ctrl_word[i] = rsr_word(on0_q[i], on1_q[i], keep0_q[i], keep1_q[i]);
			if (blk_hit[i]) begin
				rd_word = ctrl_word[i];
			end
		end
		if (reg_addr == rsr_pkg::SYS_OFF_STATUS_OFS) begin
			rd_word = {31'h0000_0000, sys_off_q};
		end
	end

	// ****************************************
	// Read port
	// ****************************************

	// Data stands for the one cycle after the strobe and is zero otherwise
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_word;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Supply and retention controls
	// ****************************************

	// Outputs lag the control bits by one cycle, so the switches see no path from the bus
	// Supply of one section: the system-off latch overrides the on bit
	function automatic logic rsr_sec_on(
		input logic on_bit,
		input logic off
	);
		return on_bit & ~off;
	endfunction

	// A powered section always keeps its contents, an unpowered one only if asked
	function automatic logic rsr_sec_keep(
		input logic on_bit,
		input logic keep_bit,
		input logic off
	);
		return rsr_sec_on(on_bit, off) | keep_bit;
	endfunction

	// Section 0 supply
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sec0_supply_on <= '1;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				sec0_supply_on[i] <= rsr_sec_on(on0_q[i], sys_off_q);
			end
		end
	end

	// Section 1 supply
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sec1_supply_on <= '1;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				sec1_supply_on[i] <= rsr_sec_on(on1_q[i], sys_off_q);
			end
		end
	end

	// ****************************************
	// Retention controls
	// ****************************************

	// Section 0 retention
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sec0_retain <= '1;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				sec0_retain[i] <= rsr_sec_keep(on0_q[i], keep0_q[i], sys_off_q);
			end
		end
	end

	// Section 1 retention
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sec1_retain <= '1;
		end else begin
			for (int i = 0; i < NUM_BLOCKS; i++) begin
				sec1_retain[i] <= rsr_sec_keep(on1_q[i], keep1_q[i], sys_off_q);
			end
		end
	end

endmodule

// [rsr_pkg.sv]
// Package of offsets, field positions and reset values for the RAM section retention registers
package rsr_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned NUM_BLOCKS = 3;

	// Register byte offsets
	localparam logic [11:0] RAM3_SECTION_CTRL_OFS = 12'h930;
	localparam logic [11:0] RAM3_SECTION_CTRL_SET_OFS = 12'h934;
	localparam logic [11:0] RAM3_SECTION_CTRL_CLEAR_OFS = 12'h938;
	localparam logic [11:0] RAM4_SECTION_CTRL_OFS = 12'h940;
	localparam logic [11:0] RAM4_SECTION_CTRL_SET_OFS = 12'h944;
	localparam logic [11:0] RAM4_SECTION_CTRL_CLEAR_OFS = 12'h948;
	localparam logic [11:0] RAM5_SECTION_CTRL_OFS = 12'h950;
	localparam logic [11:0] SYS_OFF_STATUS_OFS = 12'h9f0;

	// Field positions
	localparam int unsigned SEC0_ON_BIT = 0;
	localparam int unsigned SEC1_ON_BIT = 1;
	localparam int unsigned SEC0_KEEP_BIT = 16;
	localparam int unsigned SEC1_KEEP_BIT = 17;

	// Implemented bits and reset value
	localparam logic [31:0] CTRL_MASK = 32'h0003_0003;
	localparam logic [31:0] CTRL_RESET = 32'h0000_ffff;

endpackage

// [rsr_regs_monitor.sv]
// Checker of read timing and section outputs of the retention register bank
`timescale 1ns/1ns
module rsr_regs_monitor #(
	parameter int unsigned NUM_BLOCKS = 3
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [rsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic sys_off_req,
	input wire logic [NUM_BLOCKS-1:0] sec0_supply_on,
	input wire logic [NUM_BLOCKS-1:0] sec1_supply_on,
	input wire logic [NUM_BLOCKS-1:0] sec0_retain,
	input wire logic [NUM_BLOCKS-1:0] sec1_retain
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Latched system-off, so outputs cut by it do not count as faults
	logic off_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			off_q <= 1'b0;
		end else if (sys_off_req) begin
			off_q <= 1'b1;
		end
	end
	sequence wr_at(a);
		reg_wr && reg_addr == a;
	endsequence
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
	a_read_image: assert property (reg_rd && reg_addr == 12'h930 |=>
		reg_rdata[15:2] == 14'h3fff && reg_rdata[31:18] == 14'h0) else $error("bad read image");
	a_on_retains: assert property ((sec0_supply_on & ~sec0_retain) == '0 &&
		(sec1_supply_on & ~sec1_retain) == '0) else $error("on section not retained");
	a_sysoff_cuts: assert property (sys_off_req |-> ##[1:2]
		(sec0_supply_on == '0 && sec1_supply_on == '0)) else $error("supply not cut");
	a_clear_on: assert property (wr_at(12'h938) ##0 reg_wdata[0] |-> ##2 !sec0_supply_on[0])
		else $error("clear alias failed");
	a_set_on: assert property (wr_at(12'h934) ##0 reg_wdata[1] |-> ##2
		(sec1_supply_on[0] || off_q)) else $error("set alias failed");
	a_set_keep: assert property (wr_at(12'h944) ##0 reg_wdata[17] |-> ##2 sec1_retain[1])
		else $error("set keep failed");
	a_off_keep: assert property (wr_at(12'h950) ##0 !reg_wdata[0] |-> ##2 !sec0_supply_on[2] &&
		sec0_retain[2] == $past(reg_wdata[16], 2)) else $error("off retention wrong");
	a_alias_zero: assert property (wr_at(12'h938) ##0 reg_wdata == 32'h0 |-> ##2
		($stable(sec0_retain) || off_q)) else $error("zero write changed state");
endmodule
bind rsr_regs rsr_regs_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) rsr_regs_monitor_inst (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_off_req(sys_off_req),
	.sec0_supply_on(sec0_supply_on), .sec1_supply_on(sec1_supply_on),
	.sec0_retain(sec0_retain), .sec1_retain(sec1_retain));

// [rsr_regs_tb_top.sv]
// Self-checking bench of the retention register bank
`timescale 1ns/1ns
module rsr_regs_tb_top;
	logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sys_off_req = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [2:0] s0_on, s1_on, s0_kp, s1_kp;
	int n_fail = 0, checked = 0;
	// Write address, write data, read address, expected read data
	logic [87:0] rows [8] = '{{12'h938, 32'h00030003, 12'h934, 32'h0000fffc},
		{12'h934, 32'h00010002, 12'h938, 32'h0001fffe}, {12'h938, 32'h0, 12'h930, 32'h0001fffe},
		{12'h930, 32'hffffffff, 12'h930, 32'h0003ffff}, {12'h948, 32'h00020001, 12'h940, 32'h0000fffe},
		{12'h944, 32'h00020000, 12'h948, 32'h0002fffe}, {12'h950, 32'h00010002, 12'h950, 32'h0001fffe},
		{12'h958, 32'hffffffff, 12'h954, 32'h0}};
	rsr_regs rsr_regs_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_off_req(sys_off_req),
		.sec0_supply_on(s0_on), .sec1_supply_on(s1_on), .sec0_retain(s0_kp), .sec1_retain(s1_kp));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %0t saw %h want %h", $time, s, e);
		end
	endtask
	// One strobe cycle; a read leaves its data for sampling just after return
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask
	task automatic wrap_up;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 chk({20'h0, s0_on, s1_on, s0_kp, s1_kp}, 32'hfff);
		bus(0, 12'h940, 32'h0);
		chk(reg_rdata, 32'h0000ffff);
		foreach (rows[i]) begin
			bus(1, rows[i][87:76], rows[i][75:44]);
			bus(0, rows[i][43:32], 32'h0);
			chk(reg_rdata, rows[i][31:0]);
		end
		chk({20'h0, s0_on, s1_on, s0_kp, s1_kp}, 32'h3ef);
		@(posedge sys_clk);
		sys_off_req <= 1'b1;
		@(posedge sys_clk);
		sys_off_req <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1 chk({20'h0, s0_on, s1_on, s0_kp, s1_kp}, 32'h02b);
		bus(0, 12'h9f0, 32'h0);
		chk(reg_rdata, 32'h00000001);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		#1 chk({20'h0, s0_on, s1_on, s0_kp, s1_kp}, 32'hfff);
		bus(0, 12'h9f0, 32'h0);
		chk(reg_rdata, 32'h00000000);
		wrap_up();
	end
endmodule
